// [hw/cvrc_pkg.sv]
// package: constants and types for the comparator reference control block
// ----------------------------------------------------------------------------
// Functional notes
// RULE1: power bit seven powers ladder up or down
// RULE2: pin drive bit six overrides port direction
// RULE3: range bit five picks low or high range
// RULE4: four-bit tap code picks one of sixteen
// RULE5: bit four picks supply rails or reference pins
// RULE6: reset clears every control bit to zero
// RULE7: sleep wake leaves control register untouched
// RULE8: reference works regardless of comparator configuration
// RULE9: software should power down ladder before sleep
// RULE10: comparators take reference only in mode 110
// RULE11: write updates outputs next edge, reads return it
// ----------------------------------------------------------------------------
package cvrc_pkg;
    // register map
    localparam int CVRC_AW = 4;
    localparam logic [3:0] CVRC_ADDR_CTRL = 4'h0;
    localparam logic [3:0] CVRC_ADDR_CMODE = 4'h1;
    localparam logic [7:0] CVRC_CTRL_RST = 8'h00;
    localparam logic [2:0] CVRC_CMODE_RST = 3'h7;
    // field positions of the control register
    localparam int CVRC_B_PWR = 7;
    localparam int CVRC_B_DRV = 6;
    localparam int CVRC_B_RNG = 5;
    localparam int CVRC_B_SRC = 4;
    localparam int CVRC_TAP_HI = 3;
    localparam int CVRC_TAP_LO = 0;
    // comparator mode that routes the reference inward
    localparam logic [2:0] CVRC_CMODE_REF = 3'h6;
    // decoded ladder controls
    typedef struct packed {
        logic ladder_power_on;
        logic ref_pin_drive;
        logic range_sel;
        logic supply_src_sel;
        logic [3:0] tap_code;
    } cvrc_ctrl_t;
    // decode function used for the ladder control outputs; the register view reads the raw register
    function automatic cvrc_ctrl_t cvrc_decode(input logic [7:0] v);
        cvrc_decode.ladder_power_on = v[CVRC_B_PWR];
        cvrc_decode.ref_pin_drive = v[CVRC_B_DRV];
        cvrc_decode.range_sel = v[CVRC_B_RNG];
        cvrc_decode.supply_src_sel = v[CVRC_B_SRC];
        cvrc_decode.tap_code = v[CVRC_TAP_HI:CVRC_TAP_LO];
    endfunction
endpackage

// [hw/cvrc_pin_mux.sv]
// module: direction override for the shared reference output pin
`timescale 1ns/1ps
module cvrc_pin_mux
    import cvrc_pkg::*;
(
    // control
    input wire logic ref_pin_drive,
    input wire logic porta_direction_2,
    // pad
    output logic pad_digital_oe_b,
    output logic pad_analog_sel
);
    // reference drive wins over the port direction bit
    always_comb begin
        pad_analog_sel = ref_pin_drive; // RULE2
        pad_digital_oe_b = ref_pin_drive | porta_direction_2; // RULE2
    end
endmodule

// [hw/cvrc_top.sv]
// module: register and decode logic of the comparator reference control
`timescale 1ns/1ps
module cvrc_top
    import cvrc_pkg::*;
(
    // clock and reset
    input wire logic clk,
    input wire logic rst_b,
    input wire logic clk_en,
    // register port
    input wire logic [CVRC_AW-1:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [7:0] reg_rdata,
    // port a direction bit of the shared pin
    input wire logic porta_direction_2,
    // ladder controls
    output cvrc_ctrl_t ladder_ctrl,
    // pin controls
    output logic pad_digital_oe_b,
    output logic pad_analog_sel,
    // comparator input select
    output logic cmp_ref_sel
);
    // ------------------------------------------------------------------------
    // registers
    // ------------------------------------------------------------------------
    logic [7:0] vref_ctrl_r; // control register
    logic [2:0] cmode_r; // comparator mode copy
    logic [7:0] rdata_r; // read data register

    // control register: only reset or a write change it, so sleep wake keeps it
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            vref_ctrl_r <= CVRC_CTRL_RST; // RULE6
        end else if (clk_en && reg_wr && reg_addr == CVRC_ADDR_CTRL) begin
            vref_ctrl_r <= reg_wdata; // RULE11 RULE7
        end
    end

    // comparator mode register, independent of the reference
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            cmode_r <= CVRC_CMODE_RST;
        end else if (clk_en && reg_wr && reg_addr == CVRC_ADDR_CMODE) begin
            cmode_r <= reg_wdata[2:0];
        end
    end

    // read data, valid the cycle after the strobe; unmapped reads zero
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            rdata_r <= 8'h00;
        end else if (clk_en && reg_rd) begin
            case (reg_addr)
                CVRC_ADDR_CTRL: begin
                    rdata_r <= vref_ctrl_r; // RULE11
                end
                CVRC_ADDR_CMODE: begin
                    rdata_r <= {5'h00, cmode_r};
                end
                default: begin
                    rdata_r <= 8'h00;
                end
            endcase
        end
    end
    assign reg_rdata = rdata_r;

    // ------------------------------------------------------------------------
    // decode
    // ------------------------------------------------------------------------
    // ladder controls come straight from the register, not from comparator mode
    assign ladder_ctrl = cvrc_decode(vref_ctrl_r); // RULE1 RULE3 RULE4 RULE5 RULE8
    // reference feeds comparators only in the multiplexed mode
    assign cmp_ref_sel = (cmode_r == CVRC_CMODE_REF); // RULE10

    // pin override
    cvrc_pin_mux cvrc_pin_mux_inst (
        .ref_pin_drive(ladder_ctrl.ref_pin_drive),
        .porta_direction_2(porta_direction_2),
        .pad_digital_oe_b(pad_digital_oe_b),
        .pad_analog_sel(pad_analog_sel)
    );

    // ------------------------------------------------------------------------
    // assertion helpers
    // ------------------------------------------------------------------------
    // a control write that the register takes at this edge
    logic ctrl_wr_take;
    // a comparator mode write that the register takes at this edge
    logic cmode_wr_take;
    // a read strobe that the read port takes at this edge
    logic rd_take;
    assign ctrl_wr_take = clk_en && reg_wr && (reg_addr == CVRC_ADDR_CTRL);
    assign cmode_wr_take = clk_en && reg_wr && (reg_addr == CVRC_ADDR_CMODE);
    assign rd_take = clk_en && reg_rd;

    // ------------------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------------------
    a_write_updates: assert property (@(posedge clk) disable iff (!rst_b) // RULE11
        (clk_en && reg_wr && reg_addr == CVRC_ADDR_CTRL) |=> (vref_ctrl_r == $past(reg_wdata)))
        else $error("control write not taken");
    a_power_bit: assert property (@(posedge clk) disable iff (!rst_b) // RULE1
        ladder_ctrl.ladder_power_on == vref_ctrl_r[CVRC_B_PWR])
        else $error("power bit mismatch");
    a_pin_override: assert property (@(posedge clk) disable iff (!rst_b) // RULE2
        ladder_ctrl.ref_pin_drive |-> (pad_analog_sel && pad_digital_oe_b))
        else $error("pin drive not overriding");
    a_range_bit: assert property (@(posedge clk) disable iff (!rst_b) // RULE3
        ladder_ctrl.range_sel == vref_ctrl_r[CVRC_B_RNG])
        else $error("range bit mismatch");
    a_tap_code: assert property (@(posedge clk) disable iff (!rst_b) // RULE4
        ladder_ctrl.tap_code == vref_ctrl_r[CVRC_TAP_HI:CVRC_TAP_LO])
        else $error("tap code mismatch");
    a_src_bit: assert property (@(posedge clk) disable iff (!rst_b) // RULE5
        ladder_ctrl.supply_src_sel == vref_ctrl_r[CVRC_B_SRC])
        else $error("source bit mismatch");
    a_hold_value: assert property (@(posedge clk) disable iff (!rst_b) // RULE7
        !(reg_wr && reg_addr == CVRC_ADDR_CTRL && clk_en) |=> $stable(vref_ctrl_r))
        else $error("control changed without write");
    a_mode_indep: assert property (@(posedge clk) disable iff (!rst_b) // RULE8
        (reg_wr && reg_addr == CVRC_ADDR_CMODE) |=> $stable(ladder_ctrl))
        else $error("ladder follows comparator mode");
    a_cmp_ref: assert property (@(posedge clk) disable iff (!rst_b) // RULE10
        cmp_ref_sel == (cmode_r == CVRC_CMODE_REF))
        else $error("comparator reference select wrong");
    a_read_back: assert property (@(posedge clk) disable iff (!rst_b) // RULE11
        (clk_en && reg_rd && reg_addr == CVRC_ADDR_CTRL) |=> (reg_rdata == $past(vref_ctrl_r)))
        else $error("read back wrong");

    // ------------------------------------------------------------------------
    // assertions: each field follows the written data
    // ------------------------------------------------------------------------
    // a written one in the power bit powers the ladder up
    a_power_set: assert property (@(posedge clk) disable iff (!rst_b) // RULE1
        (ctrl_wr_take && reg_wdata[CVRC_B_PWR]) |=> ladder_ctrl.ladder_power_on)
        else $error("ladder not powered up");
    // a written zero in the power bit powers the ladder down
    a_power_clear: assert property (@(posedge clk) disable iff (!rst_b) // RULE1
        (ctrl_wr_take && !reg_wdata[CVRC_B_PWR]) |=> !ladder_ctrl.ladder_power_on)
        else $error("ladder not powered down");
    // a written drive bit routes the ladder out and turns the digital driver off
    a_drive_set: assert property (@(posedge clk) disable iff (!rst_b) // RULE2
        (ctrl_wr_take && reg_wdata[CVRC_B_DRV]) |=> (pad_analog_sel && pad_digital_oe_b))
        else $error("pin drive not applied");
    // without the drive bit the port direction alone owns the pin
    a_pin_follow: assert property (@(posedge clk) disable iff (!rst_b) // RULE2
        !ladder_ctrl.ref_pin_drive |-> (!pad_analog_sel && (pad_digital_oe_b == porta_direction_2)))
        else $error("pin not following port direction");
    // a written one in the range bit selects the low range
    a_range_low: assert property (@(posedge clk) disable iff (!rst_b) // RULE3
        (ctrl_wr_take && reg_wdata[CVRC_B_RNG]) |=> ladder_ctrl.range_sel)
        else $error("low range not selected");
    // a written zero in the range bit selects the high range
    a_range_high: assert property (@(posedge clk) disable iff (!rst_b) // RULE3
        (ctrl_wr_take && !reg_wdata[CVRC_B_RNG]) |=> !ladder_ctrl.range_sel)
        else $error("high range not selected");
    // a written one in the source bit feeds the ladder from the reference pins
    a_src_set: assert property (@(posedge clk) disable iff (!rst_b) // RULE5
        (ctrl_wr_take && reg_wdata[CVRC_B_SRC]) |=> ladder_ctrl.supply_src_sel)
        else $error("reference pin source not selected");
    // a written zero in the source bit feeds the ladder from the supply rails
    a_src_clear: assert property (@(posedge clk) disable iff (!rst_b) // RULE5
        (ctrl_wr_take && !reg_wdata[CVRC_B_SRC]) |=> !ladder_ctrl.supply_src_sel)
        else $error("supply rail source not selected");
    // the top tap is reachable
    a_tap_full: assert property (@(posedge clk) disable iff (!rst_b) // RULE4
        (ctrl_wr_take && (&reg_wdata[CVRC_TAP_HI:CVRC_TAP_LO])) |=> (&ladder_ctrl.tap_code))
        else $error("top tap not selected");
    // the bottom tap is reachable
    a_tap_zero: assert property (@(posedge clk) disable iff (!rst_b) // RULE4
        (ctrl_wr_take && (~|reg_wdata[CVRC_TAP_HI:CVRC_TAP_LO])) |=> (~|ladder_ctrl.tap_code))
        else $error("bottom tap not selected");

    // ------------------------------------------------------------------------
    // assertions: reset, clock enable and read port
    // ------------------------------------------------------------------------
    // while reset holds the reference is off, disconnected and reads zero
    a_reset_clear: assert property (@(posedge clk) // RULE6
        !rst_b |-> ((ladder_ctrl == CVRC_CTRL_RST) && !pad_analog_sel && !cmp_ref_sel && (reg_rdata == '0)))
        else $error("reset state wrong");
    // a low clock enable freezes every register of the block
    a_freeze_state: assert property (@(posedge clk) disable iff (!rst_b) // RULE7
        !clk_en |=> ($stable(vref_ctrl_r) && $stable(cmode_r) && $stable(rdata_r)))
        else $error("state moved while frozen");
    // read data stand until the next taken read
    a_read_hold: assert property (@(posedge clk) disable iff (!rst_b) // RULE11
        !rd_take |=> $stable(reg_rdata))
        else $error("read data changed without read");
    // unmapped addresses read as zero
    a_read_unmapped: assert property (@(posedge clk) disable iff (!rst_b) // RULE11
        (rd_take && reg_addr != CVRC_ADDR_CTRL && reg_addr != CVRC_ADDR_CMODE) |=> (reg_rdata == '0))
        else $error("unmapped read not zero");

    // ------------------------------------------------------------------------
    // assertions: comparator mode
    // ------------------------------------------------------------------------
    // the mode register reads back in the low bits
    a_mode_read: assert property (@(posedge clk) disable iff (!rst_b) // RULE10
        (rd_take && reg_addr == CVRC_ADDR_CMODE) |=> (reg_rdata == {5'h00, $past(cmode_r)}))
        else $error("mode read back wrong");
    // writing the multiplexed mode routes the reference inward
    a_mode_ref_on: assert property (@(posedge clk) disable iff (!rst_b) // RULE10
        (cmode_wr_take && reg_wdata[2:0] == CVRC_CMODE_REF) |=> cmp_ref_sel)
        else $error("reference not routed in its mode");
    // any other mode keeps the reference away from the comparators
    a_mode_ref_off: assert property (@(posedge clk) disable iff (!rst_b) // RULE10
        (cmode_wr_take && reg_wdata[2:0] != CVRC_CMODE_REF) |=> !cmp_ref_sel)
        else $error("reference routed in wrong mode");
endmodule

// [tb/cvrc_top_test.sv]
// testbench: self-checking bench for the comparator reference control block
`timescale 1ns/1ps
module comparator_vref_control_test;
    import cvrc_pkg::*;
    // ------------------------------
    // stimulus and observed signals
    // ------------------------------
    logic clk, rst_b, clk_en, reg_wr, reg_rd, porta_direction_2;
    logic [CVRC_AW-1:0] reg_addr;
    logic [7:0] reg_wdata, reg_rdata, rv;
    cvrc_ctrl_t ladder_ctrl;
    logic pad_digital_oe_b, pad_analog_sel, cmp_ref_sel;
    int fails = 0;
    int compares = 0;
    cvrc_top cvrc_top_inst (.clk(clk), .rst_b(rst_b), .clk_en(clk_en), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .porta_direction_2(porta_direction_2), .ladder_ctrl(ladder_ctrl),
        .pad_digital_oe_b(pad_digital_oe_b), .pad_analog_sel(pad_analog_sel), .cmp_ref_sel(cmp_ref_sel));
    // free-running 125 MHz clock
    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end
    // compare one value and count it
    task chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
        compares++;
        if (seen !== exp) begin
            fails++;
            $display("wrong value %s expected %h seen %h", what, exp, seen);
        end
    endtask
    // one-cycle write strobe; new value visible just after the taking edge
    task wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge clk);
        reg_addr <= a; reg_wdata <= d; reg_wr <= 1'b1;
        @(posedge clk);
        reg_wr <= 1'b0;
        #1;
    endtask
    // one-cycle read strobe; data sampled in the following cycle
    task rd(input logic [3:0] a, output logic [7:0] d);
        @(posedge clk);
        reg_addr <= a; reg_rd <= 1'b1;
        @(posedge clk);
        reg_rd <= 1'b0;
        #1 d = reg_rdata;
    endtask
    // ladder, analog and comparator controls cleared, oe following port direction, while reset holds and after it
    task t_reset;
        chk("ladder", ladder_ctrl, CVRC_CTRL_RST);
        chk("analog", {7'h00, pad_analog_sel}, 8'h00);
        chk("cmpsel", {7'h00, cmp_ref_sel}, 8'h00);
        chk("oe", {7'h00, pad_digital_oe_b}, {7'h00, porta_direction_2});
        rd(CVRC_ADDR_CTRL, rv);
        chk("rdback", rv, CVRC_CTRL_RST);
        rd(CVRC_ADDR_CMODE, rv);
        chk("rdmode", rv, {5'h00, CVRC_CMODE_RST});
        $display("test reset done");
    endtask
    // each field decoded and read back, each write followed by a read
    task t_fields;
        logic [7:0] pat [8] = '{8'h80, 8'h40, 8'h20, 8'h10, 8'h0F, 8'hA5, 8'hFF, 8'h00};
        foreach (pat[i]) begin
            wr(CVRC_ADDR_CTRL, pat[i]);
            chk("ladder", ladder_ctrl, pat[i]);
            chk("analog", {7'h00, pad_analog_sel}, {7'h00, pat[i][6]});
            rd(CVRC_ADDR_CTRL, rv);
            chk("rdback", rv, pat[i]);
        end
        $display("test fields done");
    endtask
    // pin drive overrides the port direction bit
    task t_pin;
        for (int i = 0; i < 4; i++) begin
            @(posedge clk);
            porta_direction_2 <= i[0];
            wr(CVRC_ADDR_CTRL, {1'b0, i[1], 6'h00});
            chk("oe", {7'h00, pad_digital_oe_b}, {7'h00, i[1] | i[0]});
        end
        $display("test pin done");
    endtask
    // every comparator mode; reference controls unaffected
    task t_mode;
        wr(CVRC_ADDR_CTRL, 8'h9A);
        for (int m = 0; m < 8; m++) begin
            wr(CVRC_ADDR_CMODE, {5'h00, m[2:0]});
            chk("cmpsel", {7'h00, cmp_ref_sel}, {7'h00, m[2:0] == 3'h6});
            chk("ladder", ladder_ctrl, 8'h9A);
            rd(CVRC_ADDR_CMODE, rv);
            chk("rdmode", rv, {5'h00, m[2:0]});
        end
        rd(4'hF, rv);
        chk("unmapped", rv, 8'h00);
        $display("test mode done");
    endtask
    // ladder powered down before a frozen clock enable, then reset in mid-run
    task t_hold;
        wr(CVRC_ADDR_CMODE, {5'h00, CVRC_CMODE_REF});
        wr(CVRC_ADDR_CTRL, 8'h1A);
        @(posedge clk);
        clk_en <= 1'b0;
        wr(CVRC_ADDR_CTRL, 8'h55);
        chk("frozen", ladder_ctrl, 8'h1A);
        rd(CVRC_ADDR_CMODE, rv);
        chk("frozenrd", rv, 8'h00);
        chk("cmpsel", {7'h00, cmp_ref_sel}, 8'h01);
        @(posedge clk);
        clk_en <= 1'b1;
        rst_b <= 1'b0;
        repeat (2) @(posedge clk);
        rst_b <= 1'b1;
        t_reset();
        $display("test hold done");
    endtask
    // single place where the run ends
    task finish_test;
        $display("compares %0d fails %0d", compares, fails);
        if (fails == 0 && compares > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask
    // watchdog well beyond the expected run of about 120 cycles
    initial begin
        repeat (3000) @(posedge clk);
        fails++;
        finish_test();
    end
    // main sequence
    initial begin
        rst_b = 1'b0; clk_en = 1'b1; reg_wr = 1'b0; reg_rd = 1'b0;
        reg_addr = 4'h0; reg_wdata = 8'h00; porta_direction_2 = 1'b1;
        repeat (16) @(posedge clk);
        rst_b <= 1'b1;
        t_reset(); t_fields(); t_pin(); t_mode(); t_hold();
        finish_test();
    end
endmodule
